// *** logic/ntsram_pkg.sv ***
package ntsram_pkg;

	localparam int ADDR_W     = 19;
	localparam int WORDS      = 524288;
	localparam int LANES      = 4;
	localparam int LANE_W     = 9;
	localparam int DATA_W     = 36;
	localparam int BURST_W    = 2;
	localparam int FIFO_DEPTH = 2;
	localparam int CNT_W      = 2;

	// Lane x occupies bits [LANE_W*x +: LANE_W]; top bit of a lane is parity
	localparam int PARITY_POS = 8;

	localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
	localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
	localparam logic [CNT_W-1:0]   FIFO_EMPTY = 2'h0;
	localparam logic [CNT_W-1:0]   FIFO_ONE   = 2'h1;
	localparam logic [CNT_W-1:0]   FIFO_FULL  = 2'h2;
	localparam logic [LANES-1:0]   LANES_OFF  = 4'hF;

	typedef enum logic [1:0] {
		NTSRAM_OP_NONE,
		NTSRAM_OP_READ,
		NTSRAM_OP_WRITE
	} ntsram_op_type;

endpackage

// *** logic/ntsram_mem.sv ***
module ntsram_mem #(
	parameter int ADDR_W = ntsram_pkg::ADDR_W,
	parameter int WORDS  = ntsram_pkg::WORDS,
	parameter int LANES  = ntsram_pkg::LANES,
	parameter int LANE_W = ntsram_pkg::LANE_W
) (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_wr_en,
	input  wire logic [ADDR_W-1:0]         i_wr_addr,
	input  wire logic [LANES-1:0]          i_wr_lane_en,
	input  wire logic [LANES*LANE_W-1:0]   i_wr_data,
	input  wire logic                      i_rd_en,
	input  wire logic [ADDR_W-1:0]         i_rd_addr,
	output logic      [LANES*LANE_W-1:0]   o_rd_data
);

	// One array per lane so each lane writes on its own enable
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [LANE_W-1:0] mem [WORDS];

		always_ff @(posedge i_sys_clk) begin
			if (i_wr_en && i_wr_lane_en[g]) begin
				mem[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
			end
			if (i_rd_en) begin
				o_rd_data[g*LANE_W +: LANE_W] <= mem[i_rd_addr];
			end
		end
	end

endmodule

// *** logic/ntsram_top.sv ***
// Behaviour
// - Array holds 524288 words of 36 bits, 19-bit address.
// - Address, data, enables and burst controls sampled on rising edge only.
// - Inputs and o_dq registered, output enable path combinational; read data pipelined, never combinational.
// - Reads and writes follow each other back to back, no idle cycle.
// - Read, write and deselect start only when advance/load is low.
// - Advance/load low captures a new external address.
// - Advance/load high steps burst counter of an active read or write burst and ignores read/write.
// - Two low address bits preset the two-bit burst counter.
// - Chip selects sampled only when a new address loads.
// - Byte enables come with the address, apply to its later data.
// - Each byte enable gates its own lane and parity bit.
// - Byte enables and read/write decide writes; array write self-timed.
// - Output enable drives data pins asynchronously.
// - Clock enable high freezes all state, extending the prior cycle.
// - Snooze high holds contents and ignores all other inputs except output enable.
// - Burst order select picks interleaved or linear sequencing.
// - Order select high gives interleaved, low gives linear.
// - Interleaved XORs start with count; linear adds modulo four.
// - Load with read/write high reads, low writes, until next load.
module ntsram_top #(
	parameter int ADDR_W = ntsram_pkg::ADDR_W,
	parameter int WORDS  = ntsram_pkg::WORDS
) (
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_rst_n,
	input  wire logic [ADDR_W-1:0]               i_addr,
	input  wire logic                            i_chip_select_first_n,
	input  wire logic                            i_chip_select_second_hi,
	input  wire logic                            i_chip_select_third_n,
	input  wire logic                            i_advance_or_load,
	input  wire logic                            i_read_write,
	input  wire logic                            i_lane_a_write_n,
	input  wire logic                            i_lane_b_write_n,
	input  wire logic                            i_lane_c_write_n,
	input  wire logic                            i_lane_d_write_n,
	input  wire logic                            i_clk_en_n,
	input  wire logic                            i_out_en_n,
	input  wire logic                            i_snooze_request,
	input  wire logic                            i_burst_order_select,
	input  wire logic [ntsram_pkg::DATA_W-1:0]   i_dq,
	input  wire logic                            i_rd_ready,
	output logic      [ntsram_pkg::DATA_W-1:0]   o_dq,
	output logic                                 o_dq_oe,
	output logic                                 o_rd_valid
);

	localparam int BW = ntsram_pkg::BURST_W;
	localparam int DW = ntsram_pkg::DATA_W;
	localparam int LN = ntsram_pkg::LANES;
	localparam int LW = ntsram_pkg::LANE_W;

	logic                          run;
	logic                          pop;
	logic                          stall;
	logic                          load;
	logic                          selected;
	logic [LN-1:0]                 lane_n;
	logic [BW-1:0]                 burst_step;
	logic [BW-1:0]                 burst_low;

	ntsram_pkg::ntsram_op_type     s1_op;
	ntsram_pkg::ntsram_op_type     next_s1_op;
	logic [ADDR_W-1:0]             s1_addr;
	logic [ADDR_W-1:0]             next_s1_addr;
	logic [LN-1:0]                 s1_bw_n;
	logic [LN-1:0]                 next_s1_bw_n;
	logic [BW-1:0]                 burst_start;
	logic [BW-1:0]                 next_burst_start;
	logic [BW-1:0]                 burst_count;
	logic [BW-1:0]                 next_burst_count;

	ntsram_pkg::ntsram_op_type     s2_op;
	ntsram_pkg::ntsram_op_type     next_s2_op;
	logic [ADDR_W-1:0]             s2_addr;
	logic [ADDR_W-1:0]             next_s2_addr;
	logic [LN-1:0]                 s2_bw_n;
	logic [LN-1:0]                 next_s2_bw_n;

	logic                          mem_we;
	logic                          mem_re;
	logic [DW-1:0]                 mem_rdata;
	logic                          fwd_hit;
	logic                          next_fwd_hit;
	logic [LN-1:0]                 fwd_be;
	logic [LN-1:0]                 next_fwd_be;
	logic [DW-1:0]                 fwd_data;
	logic [DW-1:0]                 next_fwd_data;
	logic [DW-1:0]                 rd_word;

	logic                          push;
	logic [ntsram_pkg::CNT_W-1:0]  fifo_count;
	logic [ntsram_pkg::CNT_W-1:0]  next_fifo_count;
	logic [DW-1:0]                 fifo_e0;
	logic [DW-1:0]                 next_fifo_e0;
	logic [DW-1:0]                 fifo_e1;
	logic [DW-1:0]                 next_fifo_e1;
	logic                          head_valid;
	logic                          next_head_valid;

	// Pipeline advance conditions
	always_comb begin
		run      = ~i_clk_en_n & ~i_snooze_request;
		pop      = head_valid & i_rd_ready & run;
		stall    = ~run | ((fifo_count == ntsram_pkg::FIFO_FULL) & ~pop);
		load     = ~i_advance_or_load;
		selected = ~i_chip_select_first_n & i_chip_select_second_hi
			& ~i_chip_select_third_n;
		lane_n   = {i_lane_d_write_n, i_lane_c_write_n,
			i_lane_b_write_n, i_lane_a_write_n};
		burst_step = burst_count + ntsram_pkg::BURST_ONE;
		if (i_burst_order_select) begin
			burst_low = burst_start ^ burst_step;
		end else begin
			burst_low = BW'(burst_start + burst_step);
		end
	end

	// Address stage
	always_comb begin
		next_s1_op       = s1_op;
		next_s1_addr     = s1_addr;
		next_s1_bw_n     = s1_bw_n;
		next_burst_start = burst_start;
		next_burst_count = burst_count;
		if (!stall) begin
			if (load) begin
				next_s1_addr     = i_addr;
				next_burst_start = i_addr[BW-1:0];
				next_burst_count = ntsram_pkg::BURST_RST;
				next_s1_bw_n     = lane_n;
				if (!selected) begin
					next_s1_op = ntsram_pkg::NTSRAM_OP_NONE;
				end else if (i_read_write) begin
					next_s1_op = ntsram_pkg::NTSRAM_OP_READ;
				end else begin
					next_s1_op = ntsram_pkg::NTSRAM_OP_WRITE;
				end
			end else if (s1_op != ntsram_pkg::NTSRAM_OP_NONE) begin
				next_burst_count = burst_step;
				next_s1_addr = {s1_addr[ADDR_W-1:BW], burst_low};
				next_s1_bw_n = lane_n;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s1_op       <= ntsram_pkg::NTSRAM_OP_NONE;
			s1_addr     <= '0;
			s1_bw_n     <= ntsram_pkg::LANES_OFF;
			burst_start <= ntsram_pkg::BURST_RST;
			burst_count <= ntsram_pkg::BURST_RST;
		end else begin
			s1_op       <= next_s1_op;
			s1_addr     <= next_s1_addr;
			s1_bw_n     <= next_s1_bw_n;
			burst_start <= next_burst_start;
			burst_count <= next_burst_count;
		end
	end

	// Data stage: array read issued, write data taken one stage on
	always_comb begin
		next_s2_op   = stall ? s2_op : s1_op;
		next_s2_addr = stall ? s2_addr : s1_addr;
		next_s2_bw_n = stall ? s2_bw_n : s1_bw_n;
		mem_re = ~stall & (s1_op == ntsram_pkg::NTSRAM_OP_READ);
		mem_we = ~stall & (s2_op == ntsram_pkg::NTSRAM_OP_WRITE);
		next_fwd_hit  = fwd_hit;
		next_fwd_be   = fwd_be;
		next_fwd_data = fwd_data;
		if (mem_re) begin
			next_fwd_hit  = mem_we & (s1_addr == s2_addr);
			next_fwd_be   = ~s2_bw_n;
			next_fwd_data = i_dq;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s2_op    <= ntsram_pkg::NTSRAM_OP_NONE;
			s2_addr  <= '0;
			s2_bw_n  <= ntsram_pkg::LANES_OFF;
			fwd_hit  <= 1'b0;
			fwd_be   <= '0;
			fwd_data <= '0;
		end else begin
			s2_op    <= next_s2_op;
			s2_addr  <= next_s2_addr;
			s2_bw_n  <= next_s2_bw_n;
			fwd_hit  <= next_fwd_hit;
			fwd_be   <= next_fwd_be;
			fwd_data <= next_fwd_data;
		end
	end

	ntsram_mem #(
		.ADDR_W (ADDR_W),
		.WORDS  (WORDS),
		.LANES  (LN),
		.LANE_W (LW)
	) u_mem (
		.i_sys_clk    (i_sys_clk),
		.i_wr_en      (mem_we),
		.i_wr_addr    (s2_addr),
		.i_wr_lane_en (~s2_bw_n),
		.i_wr_data    (i_dq),
		.i_rd_en      (mem_re),
		.i_rd_addr    (s1_addr),
		.o_rd_data    (mem_rdata)
	);

	// Same-edge write bypass per lane
	for (genvar g = 0; g < LN; g++) begin : g_merge
		assign rd_word[g*LW +: LW] = (fwd_hit && fwd_be[g])
			? fwd_data[g*LW +: LW] : mem_rdata[g*LW +: LW];
	end

	// Two-entry read buffer
	always_comb begin
		push            = ~stall & (s2_op == ntsram_pkg::NTSRAM_OP_READ);
		next_fifo_count = fifo_count;
		next_fifo_e0    = fifo_e0;
		next_fifo_e1    = fifo_e1;
		if (push && !pop) begin
			next_fifo_count = fifo_count + ntsram_pkg::FIFO_ONE;
			if (fifo_count == ntsram_pkg::FIFO_EMPTY) begin
				next_fifo_e0 = rd_word;
			end else begin
				next_fifo_e1 = rd_word;
			end
		end else if (pop && !push) begin
			next_fifo_count = fifo_count - ntsram_pkg::FIFO_ONE;
			next_fifo_e0    = fifo_e1;
		end else if (pop && push) begin
			if (fifo_count == ntsram_pkg::FIFO_ONE) begin
				next_fifo_e0 = rd_word;
			end else begin
				next_fifo_e0 = fifo_e1;
				next_fifo_e1 = rd_word;
			end
		end
		next_head_valid = (next_fifo_count != ntsram_pkg::FIFO_EMPTY);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			fifo_count <= ntsram_pkg::FIFO_EMPTY;
			fifo_e0    <= '0;
			fifo_e1    <= '0;
			head_valid <= 1'b0;
		end else begin
			fifo_count <= next_fifo_count;
			fifo_e0    <= next_fifo_e0;
			fifo_e1    <= next_fifo_e1;
			head_valid <= next_head_valid;
		end
	end

	assign o_dq       = fifo_e0;
	assign o_rd_valid = head_valid;
	assign o_dq_oe    = head_valid & ~i_out_en_n;

	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	property p_load_capture;
		load && !stall |=> s1_addr == $past(i_addr);
	endproperty
	a_load_capture: assert property (p_load_capture)
		else $error("new address not captured on load");
	property p_deselect;
		load && !stall && !selected |=> s1_op == ntsram_pkg::NTSRAM_OP_NONE;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("deselected load started an operation");
	property p_advance_keeps_op;
		!load && !stall |=> s1_op == $past(s1_op);
	endproperty
	a_advance_keeps_op: assert property (p_advance_keeps_op)
		else $error("advance changed read or write");
	property p_interleave;
		!load && !stall && i_burst_order_select
			&& s1_op != ntsram_pkg::NTSRAM_OP_NONE
		|=> s1_addr[BW-1:0] == (burst_start ^ burst_count);
	endproperty
	a_interleave: assert property (p_interleave)
		else $error("interleaved burst address wrong");
	property p_linear;
		!load && !stall && !i_burst_order_select
			&& s1_op != ntsram_pkg::NTSRAM_OP_NONE
		|=> s1_addr[BW-1:0] == BW'(burst_start + burst_count);
	endproperty
	a_linear: assert property (p_linear)
		else $error("linear burst address wrong");
	property p_freeze;
		!run |=> $stable(s1_addr) && $stable(s2_op) && $stable(fifo_count);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while frozen");
	property p_read_latency;
		(load && selected && i_read_write && !stall) ##1 !stall ##1 !stall
		|-> push;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read not returned two cycles after address");
	property p_write_latency;
		(load && selected && !i_read_write && !stall) ##1 !stall ##1 !stall
		|-> mem_we && s2_addr == $past(i_addr, 2);
	endproperty
	a_write_latency: assert property (p_write_latency)
		else $error("write not taken two cycles after address");
	property p_lane_gate;
		(load && selected && !i_read_write && !stall && i_lane_a_write_n)
		##1 !stall ##1 !stall |-> s2_bw_n[0];
	endproperty
	a_lane_gate: assert property (p_lane_gate)
		else $error("disabled lane a was written");
	property p_no_loss;
		fifo_count == ntsram_pkg::FIFO_FULL && !pop
		|=> $stable(fifo_e0) && $stable(fifo_e1) && $stable(s2_op);
	endproperty
	a_no_loss: assert property (p_no_loss)
		else $error("full buffer lost or moved a word");
	c_burst_read: cover property (
		(load && selected && i_read_write && !stall)
		##1 (!load && !stall) [*3]);
	c_write_after_read: cover property (
		(load && selected && i_read_write && !stall)
		##1 (load && selected && !i_read_write && !stall));
	c_buffer_full: cover property (fifo_count == ntsram_pkg::FIFO_FULL);
	c_snooze: cover property (i_snooze_request ##1 !i_snooze_request);

endmodule

// *** sim/ntsram_ctl_model.sv ***
module ntsram_ctl_model (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_order,
	output logic [ntsram_pkg::ADDR_W-1:0]  o_addr,
	output logic [2:0]                     o_sel,
	output logic                           o_adv,
	output logic                           o_rw,
	output logic [3:0]                     o_be_n,
	output logic                           o_ck_n,
	output logic                           o_zz,
	output logic [ntsram_pkg::DATA_W-1:0]  o_dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [35:0]               mem [logic [18:0]];
	logic [35:0]               exp [$];
	ntsram_pkg::ntsram_op_type op;
	ntsram_pkg::ntsram_op_type p_op [2];
	logic [18:0]               base;
	logic [18:0]               p_a [2];
	logic [1:0]                cnt;
	logic [3:0]                p_be [2];
	logic [35:0]               p_d [2];

	initial begin
		o_addr = '0;
		o_sel = 3'h4;
		o_adv = 1'b0;
		o_rw = 1'b1;
		o_be_n = 4'hF;
		o_ck_n = 1'b0;
		o_zz = 1'b0;
		o_dq = '0;
		p_op[0] = ntsram_pkg::NTSRAM_OP_NONE;
		p_op[1] = ntsram_pkg::NTSRAM_OP_NONE;
	end

	task automatic step(input logic ld, input logic rw, input logic [2:0] sel,
			input logic [18:0] a, input logic [3:0] be,
			input logic [35:0] d, input logic [1:0] frz);
		@(posedge i_sys_clk);
		#1;
		o_ck_n = frz[0];
		o_zz = frz[1];
		if (frz != 2'h0) begin
			o_dq = ~o_dq;
			o_addr = ~o_addr;
			o_sel = 3'h2;
			o_adv = 1'b0;
			o_rw = ~o_rw;
			return;
		end
		// Write data goes out two enabled cycles after its address
		o_dq = (p_op[1] == ntsram_pkg::NTSRAM_OP_WRITE)
			? p_d[1] : ~o_dq;
		if (p_op[1] == ntsram_pkg::NTSRAM_OP_WRITE) begin
			for (int i = 0; i < 4; i++)
				if (!p_be[1][i])
					mem[p_a[1]][9*i +: 9] = p_d[1][9*i +: 9];
		end else if (p_op[1] == ntsram_pkg::NTSRAM_OP_READ) begin
			exp.push_back(mem[p_a[1]]);
		end
		p_op[1] = p_op[0];
		p_a[1] = p_a[0];
		p_be[1] = p_be[0];
		p_d[1] = p_d[0];
		p_d[0] = d;
		p_be[0] = be;
		cnt = ld ? 2'h0 : cnt + 2'h1;
		if (ld) begin
			base = a;
			op = (sel != 3'h2) ? ntsram_pkg::NTSRAM_OP_NONE
				: rw ? ntsram_pkg::NTSRAM_OP_READ
				: ntsram_pkg::NTSRAM_OP_WRITE;
		end
		p_op[0] = op;
		p_a[0] = {base[18:2], i_order ? base[1:0] ^ cnt : base[1:0] + cnt};
		o_addr = ld ? a : ~o_addr;
		o_sel = sel;
		o_adv = ~ld;
		o_rw = ld ? rw : ~o_rw;
		o_be_n = be;
	endtask
endmodule

// *** sim/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst_n;
	logic        order;
	logic        out_en_n;
	logic        rd_ready;
	logic [18:0] addr;
	logic [2:0]  sel;
	logic        advance_or_load;
	logic        rw;
	logic        ck_n;
	logic        zz;
	logic [3:0]  be_n;
	logic [35:0] dq_in;
	logic [35:0] dq_out;
	logic        dq_oe;
	logic        rd_valid;
	int          n_fail;
	int          samples_checked;

	ntsram_top ntsram_top_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_chip_select_first_n(sel[2]), .i_chip_select_second_hi(sel[1]),
		.i_chip_select_third_n(sel[0]), .i_advance_or_load(advance_or_load),
		.i_read_write(rw), .i_lane_a_write_n(be_n[0]),
		.i_lane_b_write_n(be_n[1]), .i_lane_c_write_n(be_n[2]),
		.i_lane_d_write_n(be_n[3]), .i_clk_en_n(ck_n), .i_out_en_n(out_en_n),
		.i_snooze_request(zz), .i_burst_order_select(order), .i_dq(dq_in),
		.i_rd_ready(rd_ready), .o_dq(dq_out), .o_dq_oe(dq_oe),
		.o_rd_valid(rd_valid));
	ntsram_ctl_model ntsram_ctl_model_inst (.i_sys_clk(clk), .i_order(order),
		.o_addr(addr), .o_sel(sel), .o_adv(advance_or_load), .o_rw(rw), .o_be_n(be_n),
		.o_ck_n(ck_n), .o_zz(zz), .o_dq(dq_in));

	task automatic chk1(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk36(input string nm, input logic [35:0] e,
			input logic [35:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [18:0] a, input logic [3:0] be,
			input logic [35:0] d);
		ntsram_ctl_model_inst.step(1'b1, 1'b0, 3'h2, a, be, d, 2'h0);
	endtask
	task automatic rd(input logic [18:0] a, input logic [2:0] s);
		ntsram_ctl_model_inst.step(1'b1, 1'b1, s, a, 4'hF, '0, 2'h0);
	endtask
	task automatic bst(input logic [3:0] be, input logic [35:0] d,
			input logic [1:0] f);
		ntsram_ctl_model_inst.step(1'b0, 1'b0, 3'h5, '0, be, d, f);
	endtask
	task automatic nop();
		rd('0, 3'h3);
	endtask
	task automatic drain();
		nop();
		nop();
		for (int i = 0; i < 30; i++) begin
			if (ntsram_ctl_model_inst.exp.size() == 0 && rd_valid === 1'b0)
				return;
			nop();
		end
		chk1("drain_timeout", 1'b0, 1'b1);
		results();
	endtask

	// Pop check on every accepted head word
	always @(negedge clk)
		if (rst_n && rd_valid === 1'b1 && rd_ready && !ck_n && !zz) begin
			if (ntsram_ctl_model_inst.exp.size() == 0)
				chk1("word_unexpected", 1'b0, 1'b1);
			else
				chk36("o_dq", ntsram_ctl_model_inst.exp.pop_front(), dq_out);
		end

	task automatic s_reset();
		chk1("o_rd_valid", 1'b0, rd_valid);
		chk1("o_dq_oe", 1'b0, dq_oe);
		chk36("o_dq", '0, dq_out);
	endtask
	task automatic s_turn();
		wr(19'h7FFFF, 4'h0, 36'h1_2345_6789);
		rd(19'h7FFFF, 3'h2);
		wr(19'h00000, 4'h0, 36'hF_EDCB_A987);
		rd(19'h00000, 3'h2);
		rd(19'h7FFFF, 3'h2);
		drain();
	endtask
	task automatic s_burst(input logic o, input logic [1:0] st);
		logic [18:0] a;
		a = {17'h0ABCD, st};
		order = o;
		nop();
		for (int i = 0; i < 4; i++)
			wr({a[18:2], 2'(i)}, 4'h0, 36'hC_0000_0000 + 36'(i));
		rd(a, 3'h2);
		for (int i = 1; i < 8; i++)
			bst(4'hF, '0, 2'h0);
		wr(a, 4'h0, 36'h3_0000_0000);
		for (int i = 1; i < 4; i++)
			bst(4'h0, 36'h3_0000_0000 + 36'(i), 2'h0);
		for (int i = 0; i < 4; i++)
			rd({a[18:2], 2'(i)}, 3'h2);
		drain();
	endtask
	task automatic s_lanes();
		for (int i = 0; i < 4; i++) begin
			wr(19'h00300, 4'h0, 36'h0);
			wr(19'h00300, ~(4'h1 << i), 36'hF_FFFF_FFFF);
			rd(19'h00300, 3'h2);
		end
		wr(19'h00300, 4'hF, 36'h5_5555_5555);
		rd(19'h00300, 3'h2);
		drain();
	endtask
	task automatic s_select();
		wr(19'h00400, 4'h0, 36'h7_7777_7777);
		for (int i = 0; i < 3; i++) begin
			ntsram_ctl_model_inst.step(1'b1, 1'b0, 3'h2 ^ (3'h1 << i),
				19'h00400, 4'h0, 36'h0, 2'h0);
			bst(4'h0, 36'h0, 2'h0);
			rd(19'h00400, 3'h2 ^ (3'h1 << i));
		end
		rd(19'h00400, 3'h2);
		drain();
	endtask
	task automatic s_freeze();
		wr(19'h00500, 4'h0, 36'h1_1111_1111);
		bst(4'h0, '0, 2'h1);
		bst(4'h0, 36'h2_2222_2222, 2'h0);
		bst(4'h0, '0, 2'h2);
		bst(4'h0, 36'h3_3333_3333, 2'h0);
		rd(19'h00500, 3'h2);
		bst(4'hF, '0, 2'h2);
		bst(4'hF, '0, 2'h0);
		bst(4'hF, '0, 2'h1);
		bst(4'hF, '0, 2'h0);
		drain();
	endtask
	task automatic s_buffer();
		for (int i = 0; i < 3; i++)
			wr(19'h00600 + 19'(i), 4'h0, 36'hA_0000_0000 + 36'(i));
		rd_ready = 1'b0;
		for (int i = 0; i < 3; i++)
			rd(19'h00600 + 19'(i), 3'h2);
		for (int i = 0; i < 6; i++)
			nop();
		chk1("o_rd_valid", 1'b1, rd_valid);
		chk36("o_dq", 36'hA_0000_0000, dq_out);
		out_en_n = 1'b1;
		#2;
		chk1("o_dq_oe", 1'b0, dq_oe);
		nop();
		out_en_n = 1'b0;
		#2;
		chk1("o_dq_oe", 1'b1, dq_oe);
		nop();
		rd_ready = 1'b1;
		drain();
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		n_fail = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		order = 1'b1;
		out_en_n = 1'b0;
		rd_ready = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		s_reset();
		s_turn();
		s_burst(1'b1, 2'h1);
		s_burst(1'b0, 2'h3);
		s_burst(1'b0, 2'h1);
		s_lanes();
		s_select();
		s_freeze();
		s_buffer();
		results();
	end
endmodule
